// File: design/jsu_pkg.sv
// Constants, state codes and carrier types for the JTAG security unlock block
package jsu_pkg;

    // ==========================================================
    // Code and address layout
    localparam int          CODE_W           = 128;
    localparam logic [31:0] OTP_CODE_ADDR    = 32'hf000_0000;
    localparam int          IR_W             = 4;

    // ==========================================================
    // Instruction codes of the security unit's TAP
    localparam logic [3:0]  IR_UNLOCK        = 4'hb;
    localparam logic [3:0]  IR_BSCAN         = 4'h1;
    localparam logic [3:0]  IR_BYPASS        = 4'hf;
    localparam logic [3:0]  IR_CAPTURE       = 4'h1;

    // ==========================================================
    // Routing of the debug router
    localparam int          SEC_TAP_N        = 4;
    localparam int          SEC_TAP_SECURITY = 2;

    // ==========================================================
    // Hidden tie-offs and hidden compare value; arbitrary defaults
    localparam logic [127:0] TIE_OFF_DEFAULT  = {4{32'h5a3c_96e1}};
    localparam logic [127:0] FACTORY_DEFAULT  = {4{32'hffff_ffff}};

    // ==========================================================
    // Timing of the sampled test clock
    localparam real         CLOCK_PERIOD_NS  = 5.0;
    localparam int          SYNC_STAGES      = 2;

    // ==========================================================
    // TAP controller states
    typedef enum logic [3:0] {
        TAP_RESET     = 4'hf,
        TAP_IDLE      = 4'hc,
        TAP_SEL_DR    = 4'h7,
        TAP_CAP_DR    = 4'h6,
        TAP_SHIFT_DR  = 4'h2,
        TAP_EXIT1_DR  = 4'h1,
        TAP_PAUSE_DR  = 4'h3,
        TAP_EXIT2_DR  = 4'h0,
        TAP_UPD_DR    = 4'h5,
        TAP_SEL_IR    = 4'h4,
        TAP_CAP_IR    = 4'he,
        TAP_SHIFT_IR  = 4'ha,
        TAP_EXIT1_IR  = 4'h9,
        TAP_PAUSE_IR  = 4'hb,
        TAP_EXIT2_IR  = 4'h8,
        TAP_UPD_IR    = 4'hd
    } jsu_tap_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jsu_jtag_in_t;

    typedef struct packed {
        logic [SEC_TAP_N-1:0] sec_tap_en;
        logic                 test_tap_en;
        logic                 bscan_en;
    } jsu_route_t;

endpackage : jsu_pkg

// File: design/jsu_sync.sv
// Two-stage synchroniser for inputs from outside the CLOCK domain
`timescale 1ns/1ps
module jsu_sync #(
    parameter int W = 1
) (
    input  wire logic         CLOCK,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second; no reset so no constant glitch
    always_ff @(posedge CLOCK) begin
        meta <= d;
        q    <= meta;
    end
endmodule : jsu_sync

// File: design/jsu_jtag_security_unlock.sv
// JTAG security unit: scan unlock register, unlock compare and TAP gating
//
// Contract
// R1: XOR OTP visible code with scan unlock register
// R2: Mix tie-offs, compare hidden value, drive unlock
// R3: OTP code read-only; cleared bits lock device
// R4: All-zero visible code keeps device locked forever
// R5: IR 0b1011 selects scan unlock register
// R6: Tester scans value restoring factory code
// R7: Only power-on reset clears scan unlock register
// R8: Locked: only secondary TAP 2 reachable
// R9: Boundary scan from TDI through chain to TDO
// R10: Unlock evaluated continuously, gating follows promptly
`timescale 1ns/1ps
module jsu_jtag_security_unlock #(
    parameter logic [127:0] TIE_OFF      = jsu_pkg::TIE_OFF_DEFAULT,
    parameter logic [127:0] FACTORY_CODE = jsu_pkg::FACTORY_DEFAULT
) (
    input  wire logic                             CLOCK,
    input  wire logic                             RESET,
    input  wire logic                             POWER_ON_RESET_N,
    input  wire jsu_pkg::jsu_jtag_in_t            JTAG_IN,
    output logic                                  TEST_DATA_OUT,
    output logic                                  TEST_DATA_OUT_EN,
    output logic                                  RETURNED_TEST_CLOCK,
    input  wire logic [jsu_pkg::CODE_W-1:0]       OTP_UNLOCK_CODE,
    input  wire jsu_pkg::jsu_route_t              ROUTE_REQUEST,
    output jsu_pkg::jsu_route_t                   ROUTE_GRANT,
    output logic                                  UNLOCK,
    output logic                                  BSCAN_SERIAL_OUT,
    output logic                                  BSCAN_SHIFT,
    input  wire logic                             BSCAN_SERIAL_IN
);
    import jsu_pkg::*;

    // ==========================================================
    // Synchronisers
    logic [4:0]     pin_sync;
    jsu_jtag_in_t   jtag;
    logic           por_n;
    logic           bscan_ret;

    jsu_sync #(
        .W (5)
    ) u_sync (
        .CLOCK (CLOCK),
        .d     ({JTAG_IN.tck, JTAG_IN.tms, JTAG_IN.tdi, POWER_ON_RESET_N, BSCAN_SERIAL_IN}),
        .q     (pin_sync)
    );

    // Synchronised pins by name
    assign jtag      = pin_sync[4:2];
    assign por_n     = pin_sync[1];
    assign bscan_ret = pin_sync[0];

    // ==========================================================
    // Test clock edge detection
    logic tck_prev;
    wire  tck_rise = jtag.tck & ~tck_prev;
    wire  tck_fall = ~jtag.tck & tck_prev;

    // Edge history; the returned clock shows where the sampling really lands
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            tck_prev            <= 1'b0;
            RETURNED_TEST_CLOCK <= 1'b0;
        end else begin
            tck_prev            <= jtag.tck;
            RETURNED_TEST_CLOCK <= jtag.tck;
        end
    end

    // ==========================================================
    // TAP controller
    jsu_tap_state_t state;
    jsu_tap_state_t next_state;

    function automatic jsu_tap_state_t tap_next(input jsu_tap_state_t s, input logic tms);
        unique case (s)
            TAP_RESET:    tap_next = tms ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   tap_next = tms ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
        endcase
    endfunction : tap_next

    assign next_state = tap_next(state, jtag.tms);

    // Power-on reset also puts the TAP in a known state
    wire logic_reset = RESET | ~por_n;

    // State advances on the sampled rising test clock edge
    always_ff @(posedge CLOCK) begin
        if (logic_reset) begin
            state <= TAP_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Unlock evaluation and instruction decode
    logic [CODE_W-1:0] scan_unlock_register;
    logic [IR_W-1:0]   ir;
    logic              unlocked;

    wire [CODE_W-1:0] xor_code    = OTP_UNLOCK_CODE ^ scan_unlock_register;  // R1
    wire [CODE_W-1:0] mixed_code  = xor_code ^ TIE_OFF;                      // R2
    wire [CODE_W-1:0] hidden_code = FACTORY_CODE ^ TIE_OFF;
    // Cleared OTP bits break the match; the code is never written here
    wire              code_match  = (mixed_code == hidden_code);             // R3
    wire              code_valid  = |OTP_UNLOCK_CODE;                        // R4
    // Evaluated from live contents every cycle, no sequencing needed
    wire              next_unlock = code_valid & code_match;                 // R10

    wire sel_unlock_dr = (ir == IR_UNLOCK);                                  // R5
    // Boundary scan instruction is dead while locked, falls to bypass
    wire sel_bscan_dr  = (ir == IR_BSCAN) & unlocked;                        // R8
    wire in_shift_dr   = (state == TAP_SHIFT_DR);
    wire in_shift_ir   = (state == TAP_SHIFT_IR);

    // Unlock flag registered so gating outputs come from flip-flops
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            unlocked <= 1'b0;
        end else begin
            unlocked <= next_unlock;                                         // R2
        end
    end

    // ==========================================================
    // Instruction and data shift paths
    logic [IR_W-1:0]   ir_shift;
    logic [CODE_W-1:0] dr_shift;
    logic              bypass;

    // Capture of the unlock path reads zeros so the secret never leaks out
    always_ff @(posedge CLOCK) begin
        if (logic_reset) begin
            ir       <= IR_BYPASS;
            ir_shift <= IR_CAPTURE;
            dr_shift <= '0;
            bypass   <= 1'b0;
        end else if (tck_rise) begin
            unique case (state)
                TAP_RESET:    ir       <= IR_BYPASS;
                TAP_CAP_IR:   ir_shift <= IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift <= {jtag.tdi, ir_shift[IR_W-1:1]};
                TAP_UPD_IR:   ir       <= ir_shift;
                TAP_CAP_DR: begin
                    dr_shift <= '0;
                    bypass   <= 1'b0;
                end
                TAP_SHIFT_DR: begin
                    if (sel_unlock_dr) begin
                        dr_shift <= {jtag.tdi, dr_shift[CODE_W-1:1]};        // R5
                    end
                    bypass <= jtag.tdi;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Scan unlock register; system reset and TAP reset leave it alone
    always_ff @(posedge CLOCK) begin
        if (!por_n) begin
            scan_unlock_register <= '0;                                      // R7
        end else if (tck_rise && state == TAP_UPD_DR && sel_unlock_dr) begin
            scan_unlock_register <= dr_shift;                                // R6
        end
    end

    // ==========================================================
    // Test data out, changed on the falling test clock edge
    wire tdo_bit = in_shift_ir   ? ir_shift[0] :
                   sel_unlock_dr ? dr_shift[0] :
                   sel_bscan_dr  ? bscan_ret   : bypass;                     // R9

    always_ff @(posedge CLOCK) begin
        if (logic_reset) begin
            TEST_DATA_OUT    <= 1'b0;
            TEST_DATA_OUT_EN <= 1'b0;
        end else if (tck_fall) begin
            TEST_DATA_OUT    <= tdo_bit;
            TEST_DATA_OUT_EN <= in_shift_ir | in_shift_dr;
        end
    end

    // ==========================================================
    // Boundary-scan chain hookup: TDI in, chain return to TDO
    always_ff @(posedge CLOCK) begin
        if (logic_reset) begin
            BSCAN_SERIAL_OUT <= 1'b0;
            BSCAN_SHIFT      <= 1'b0;
        end else begin
            BSCAN_SERIAL_OUT <= jtag.tdi;                                    // R9
            BSCAN_SHIFT      <= sel_bscan_dr & in_shift_dr & tck_rise;       // R9
        end
    end

    // ==========================================================
    // Router gating; the security unit's own path is never cut
    jsu_route_t next_grant;

    always_comb begin
        next_grant             = '0;
        next_grant.sec_tap_en  = ROUTE_REQUEST.sec_tap_en & {SEC_TAP_N{unlocked}};   // R8
        next_grant.sec_tap_en[SEC_TAP_SECURITY] = ROUTE_REQUEST.sec_tap_en[SEC_TAP_SECURITY];
        next_grant.test_tap_en = ROUTE_REQUEST.test_tap_en & unlocked;      // R8
        next_grant.bscan_en    = ROUTE_REQUEST.bscan_en & unlocked;         // R8
    end

    // Gate and flag registered together so they never disagree
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ROUTE_GRANT <= '0;
            UNLOCK      <= 1'b0;
        end else begin
            ROUTE_GRANT <= next_grant;                                       // R10
            UNLOCK      <= unlocked;
        end
    end

endmodule : jsu_jtag_security_unlock

// File: bench/jsu_properties.sv
// Port-level assertions of the JTAG security unlock block
`timescale 1ns/1ps
module jsu_properties
    import jsu_pkg::*;
(
    input wire logic                         CLOCK,
    input wire logic                         RESET,
    input wire jsu_pkg::jsu_jtag_in_t        JTAG_IN,
    input wire logic [jsu_pkg::CODE_W-1:0]   OTP_UNLOCK_CODE,
    input wire jsu_pkg::jsu_route_t          ROUTE_REQUEST,
    input wire jsu_pkg::jsu_route_t          ROUTE_GRANT,
    input wire logic                         UNLOCK,
    input wire logic                         RETURNED_TEST_CLOCK,
    input wire logic                         BSCAN_SERIAL_OUT,
    input wire logic                         BSCAN_SHIFT
);
    // ==========================================================
    // Settling count: outputs are trusted only from 3 edges after reset
    logic [1:0] up;
    logic       ok;
    assign ok = (up == 2'h3);
    always_ff @(posedge CLOCK) begin
        if (RESET) up <= 2'h0;
        else if (!ok) up <= up + 2'h1;
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    // ==========================================================
    // Assertions
    a_zero_code_locked: assert property ((OTP_UNLOCK_CODE == '0) [*3] |-> !UNLOCK)
        else $error("unlock raised with an all-zero code");
    a_grant_locked: assert property (ok && !UNLOCK |-> ROUTE_GRANT == ($past(ROUTE_REQUEST) & 6'h10))
        else $error("locked grant passes more than the security tap");
    a_grant_open: assert property (ok && UNLOCK |-> ROUTE_GRANT == $past(ROUTE_REQUEST))
        else $error("unlocked grant differs from request");
    a_bscan_cut_off: assert property (ok && !UNLOCK |-> !BSCAN_SHIFT)
        else $error("boundary shift while locked");
    a_bscan_data_path: assert property (BSCAN_SHIFT |-> BSCAN_SERIAL_OUT == $past(JTAG_IN.tdi, 3))
        else $error("chain input is not the test data input");
    a_shift_one_pulse: assert property (BSCAN_SHIFT |=> !BSCAN_SHIFT)
        else $error("boundary shift longer than one cycle");
    a_ret_clock_follows: assert property ($rose(JTAG_IN.tck) |-> ##[1:5] RETURNED_TEST_CLOCK)
        else $error("returned clock late");
    a_reset_quiet: assert property ($fell(RESET) |-> !UNLOCK && ROUTE_GRANT == '0 && !BSCAN_SHIFT)
        else $error("outputs active right after reset");

    c_unlocked: cover property (ok && UNLOCK);
    c_locked: cover property (ok && $fell(UNLOCK));
    c_bscan: cover property (BSCAN_SHIFT);
endmodule : jsu_properties

bind jsu_jtag_security_unlock jsu_properties chk (.CLOCK(CLOCK), .RESET(RESET),
    .JTAG_IN(JTAG_IN), .OTP_UNLOCK_CODE(OTP_UNLOCK_CODE), .ROUTE_REQUEST(ROUTE_REQUEST),
    .ROUTE_GRANT(ROUTE_GRANT), .UNLOCK(UNLOCK), .RETURNED_TEST_CLOCK(RETURNED_TEST_CLOCK),
    .BSCAN_SERIAL_OUT(BSCAN_SERIAL_OUT), .BSCAN_SHIFT(BSCAN_SHIFT));

// File: bench/jsu_tester.sv
// Behavioural JTAG tester driving the test pins of the unlock block
`timescale 1ns/1ps
module jsu_tester
    import jsu_pkg::*;
(
    output jsu_pkg::jsu_jtag_in_t jtag_in,
    input  wire logic             tdo
);
    int ones;
    // ==========================================================
    // Test clock stands low between frames
    initial jtag_in = '0;

    // One 48 ns period; tms and tdi move only while tck is low
    task automatic tick(input logic tms, input logic tdi, input logic smp = 1'b0);
        jtag_in.tms = tms;
        jtag_in.tdi = tdi;
        #24;
        if (smp) ones += int'(tdo === 1'b1);
        jtag_in.tck = 1'b1;
        #24;
        jtag_in.tck = 1'b0;
    endtask : tick

    // Frame from any state: reset, IR load, n DR bits LSB first, back to idle
    task automatic frame(input logic [3:0] ir, input logic [127:0] dr, input int n);
        ones = 0;
        for (int i = 0; i < 10; i++) begin
            tick(i < 5 || i == 6 || i == 7, ~jtag_in.tdi);
        end
        for (int i = 0; i < 4; i++) begin
            tick(i == 3, ir[i]);
        end
        for (int i = 0; i < 4; i++) begin
            tick(i < 2, ~jtag_in.tdi);
        end
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, dr[i], 1'b1);
        end
        tick(1'b1, ~jtag_in.tdi);
        tick(1'b0, ~jtag_in.tdi);
    endtask : frame
endmodule : jsu_tester

// File: bench/jsu_jtag_security_unlock_tb.sv
// Self-checking bench of the JTAG security unlock block
`timescale 1ns/1ps
module jsu_jtag_security_unlock_tb;
    import jsu_pkg::*;
    localparam logic [127:0] FAC = {4{32'hfedc_ba98}};
    logic         clock;
    logic         reset;
    logic         por_n;
    logic         bscan_in;
    logic [127:0] otp;
    jsu_route_t   req;
    jsu_route_t   grant;
    jsu_jtag_in_t jin;
    logic         tdo;
    logic         unl;
    logic         bshift;
    logic         tdo_en;
    logic         en_seen;
    int           n_fail;
    int           samples_checked;
    int           shifts;

    // ==========================================================
    // Clock, unit and tester
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    jsu_jtag_security_unlock #(.FACTORY_CODE(FAC)) uut (.CLOCK(clock), .RESET(reset),
        .POWER_ON_RESET_N(por_n), .JTAG_IN(jin), .TEST_DATA_OUT(tdo), .TEST_DATA_OUT_EN(tdo_en),
        .RETURNED_TEST_CLOCK(), .OTP_UNLOCK_CODE(otp), .ROUTE_REQUEST(req),
        .ROUTE_GRANT(grant), .UNLOCK(unl), .BSCAN_SERIAL_OUT(), .BSCAN_SHIFT(bshift),
        .BSCAN_SERIAL_IN(bscan_in));
    jsu_tester tester (.jtag_in(jin), .tdo(tdo));
    // Boundary shift pulses counted one per clock; data enable seen at least once
    always @(posedge clock) begin
        if (bshift === 1'b1) shifts++;
        if (tdo_en === 1'b1) en_seen = 1'b1;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic idle(input int c);
        repeat (c) @(negedge clock);
    endtask : idle
    // Boundary frame of 8 bits; chain return is held high
    task automatic bscan(input logic [7:0] exp);
        shifts = 0;
        en_seen = 1'b0;
        tester.frame(IR_BSCAN, 128'h0, 8);
        idle(8);
        check("bscan shifts", exp, 8'(shifts));
        check("tdo ones", exp, 8'(tester.ones));
        check("tdo enable seen", 8'h1, 8'(en_seen));
        check("tdo enable idle", 8'h0, 8'(tdo_en));
    endtask : bscan

    // ==========================================================
    // Scenarios
    task automatic t_locked();
        check("unlock", 8'h1, 8'(unl));
        otp = FAC & ~128'hff;
        req = 6'h3b;
        idle(4);
        check("unlock", 8'h0, 8'(unl));
        check("grant", 8'h10, 8'(grant));
        bscan(8'h0);
        $display("test locked done");
    endtask : t_locked
    task automatic t_scan();
        tester.frame(IR_BYPASS, otp ^ FAC, 128);
        idle(8);
        check("unlock", 8'h0, 8'(unl));
        tester.frame(IR_UNLOCK, otp ^ FAC, 128);
        idle(8);
        check("unlock", 8'h1, 8'(unl));
        check("grant", 8'h3b, 8'(grant));
        bscan(8'h8);
        $display("test scan unlock done");
    endtask : t_scan
    task automatic t_resets();
        reset = 1'b1;
        idle(3);
        reset = 1'b0;
        idle(6);
        check("unlock", 8'h1, 8'(unl));
        por_n = 1'b0;
        idle(6);
        por_n = 1'b1;
        idle(6);
        check("unlock", 8'h0, 8'(unl));
        otp = '0;
        tester.frame(IR_UNLOCK, FAC, 128);
        idle(8);
        check("unlock", 8'h0, 8'(unl));
        $display("test resets and zero code done");
    endtask : t_resets

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        reset = 1'b1;
        por_n = 1'b0;
        bscan_in = 1'b1;
        otp = FAC;
        req = '1;
        repeat (20) @(negedge clock);
        reset = 1'b0;
        por_n = 1'b1;
        idle(6);
        t_locked();
        t_scan();
        t_resets();
        finish_test();
    end
    // Watchdog: five frames, three of about 7 us and two of about 1.3 us, fit well inside 100 us
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end
endmodule : jsu_jtag_security_unlock_tb
